// ==== logic/global_ctrl_defines.vh ====
// Register offsets, field positions and reset values of the global control bank
`ifndef GLOBAL_CTRL_DEFINES_VH
`define GLOBAL_CTRL_DEFINES_VH
`define ADDR_SLIP_AUTOTUNE 12'h0002
`define ADDR_GLOBAL_ENABLE 12'h0003
`define ADDR_CHANNEL_PAIR 12'h0004
`define ADDR_GLOBAL_MODE 12'h0005
`define ADDR_ALARM_CLEAR 12'h0006
`define ADDR_MISC_RESERVED 12'h0007
`define ADDR_SCRATCHPAD 12'h0008
`define ADDR_LOCK_ALIGN 12'h0009
`define BIT_SLIP_REQUEST 1
`define BIT_AUTOTUNE 2
`define BIT_REF_LOOP_EN 0
`define BIT_SYN_LOOP_EN 1
`define BIT_SYSREF_TIMER_EN 2
`define BIT_RF_RESEED_EN 5
`define BIT_REF_ONE_EXT_VCO 5
`define BIT_REF_ZERO_RF_SYNC 4
`define BIT_CLEAR_ALARMS 0
`define BIT_LOCK_ALIGN_DIS 0
`define SYNC_MODE_OFF 2'b00
`define SYNC_MODE_ALIGN 2'b01
`define SYNC_MODE_PULSE 2'b10
`define SYNC_MODE_AUTO 2'b11
`define RST_REG 8'h00
`endif

// ==== logic/global_control_registers.v ====
// Global control register bank with slip, alignment and enable logic
`include "global_ctrl_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module global_control_registers (
  // Clock and reset
  input wire REF_CLK,
  input wire ARST_N,
  // Serial-port register access, already deserialised
  input wire WR_EN,
  input wire RD_EN,
  input wire [11:0] ADDR,
  input wire [7:0] WDATA,
  output reg [7:0] RDATA,
  output reg RVALID,
  // Status from the rest of the device
  input wire SLIP_DONE,
  input wire ALARM_PRESENT,
  input wire SYN_LOOP_LOCKED,
  input wire SYNC_PIN,
  input wire GPI_PULSE_REQ,
  // Controls to the rest of the device
  output reg SLIP_REQ,
  output reg AUTOTUNE_START,
  output reg REF_LOOP_EN,
  output reg SYN_LOOP_EN,
  output reg SYSREF_TIMER_EN,
  output reg RF_RESEED_EN,
  output reg [1:0] VCO_SELECT,
  output reg [13:0] CHANNEL_EN,
  output reg REF_ONE_EXT_VCO,
  output reg REF_ZERO_RF_SYNC,
  output reg [3:0] REF_PATH_EN,
  output reg ALIGN_EVENT,
  output reg PULSE_GEN_REQ,
  output reg ALARM_CLEAR_PULSE,
  output reg PHASE_SYNC_ALARM
);

  reg [7:0] reg_slip;
  reg [7:0] reg_enable;
  reg [7:0] reg_pairs;
  reg [7:0] reg_mode;
  reg [7:0] reg_clear;
  reg [7:0] reg_misc;
  reg [7:0] reg_scratch;
  reg [7:0] reg_lock;
  reg slip_prev;
  reg slip_busy;
  reg sync_prev;
  reg lock_prev;
  reg [7:0] next_rdata;
  wire [13:0] next_channel_en;
  wire slip_rise;
  wire sync_rise;
  wire lock_rise;
  wire [1:0] pin_mode;

  // Address match used by the write path and the write-strobe decodes; the read mux uses its own case
  function hit;
    input [11:0] a;
    input [11:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // Register writes
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      reg_slip <= `RST_REG;
      reg_enable <= `RST_REG;
      reg_pairs <= `RST_REG;
      reg_mode <= `RST_REG;
      reg_clear <= `RST_REG;
      reg_misc <= `RST_REG;
      reg_scratch <= `RST_REG;
      reg_lock <= `RST_REG;
    end else if (WR_EN) begin
      if (hit(ADDR, `ADDR_SLIP_AUTOTUNE)) reg_slip <= WDATA;
      if (hit(ADDR, `ADDR_GLOBAL_ENABLE)) reg_enable <= WDATA;
      if (hit(ADDR, `ADDR_CHANNEL_PAIR)) reg_pairs <= WDATA;
      if (hit(ADDR, `ADDR_GLOBAL_MODE)) reg_mode <= WDATA;
      if (hit(ADDR, `ADDR_ALARM_CLEAR)) reg_clear <= WDATA;
      if (hit(ADDR, `ADDR_MISC_RESERVED)) reg_misc <= WDATA;
      if (hit(ADDR, `ADDR_SCRATCHPAD)) reg_scratch <= WDATA;
      if (hit(ADDR, `ADDR_LOCK_ALIGN)) reg_lock <= WDATA;
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    next_rdata = 8'h00;
    case (ADDR)
      `ADDR_SLIP_AUTOTUNE: next_rdata = reg_slip;
      `ADDR_GLOBAL_ENABLE: next_rdata = reg_enable;
      `ADDR_CHANNEL_PAIR: next_rdata = reg_pairs;
      `ADDR_GLOBAL_MODE: next_rdata = reg_mode;
      `ADDR_ALARM_CLEAR: next_rdata = reg_clear;
      `ADDR_MISC_RESERVED: next_rdata = reg_misc;
      `ADDR_SCRATCHPAD: next_rdata = reg_scratch;
      `ADDR_LOCK_ALIGN: next_rdata = reg_lock;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
      RVALID <= 1'b0;
    end else begin
      RVALID <= RD_EN;
      if (RD_EN) RDATA <= next_rdata;
    end
  end

  // Channel pair expansion
  genvar k;
  generate
    for (k = 0; k < 7; k = k + 1) begin : g_pair
      assign next_channel_en[2*k] = reg_pairs[k];
      assign next_channel_en[2*k+1] = reg_pairs[k];
    end
  endgenerate

  // Edge detectors on requests and status inputs
  assign slip_rise = reg_slip[`BIT_SLIP_REQUEST] & ~slip_prev;
  assign sync_rise = SYNC_PIN & ~sync_prev;
  assign lock_rise = SYN_LOOP_LOCKED & ~lock_prev;
  assign pin_mode = reg_mode[7:6];

  // Level controls registered onto the outputs
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REF_LOOP_EN <= 1'b0;
      SYN_LOOP_EN <= 1'b0;
      SYSREF_TIMER_EN <= 1'b0;
      RF_RESEED_EN <= 1'b0;
      VCO_SELECT <= 2'b00;
      CHANNEL_EN <= 14'h0000;
      REF_ONE_EXT_VCO <= 1'b0;
      REF_ZERO_RF_SYNC <= 1'b0;
      REF_PATH_EN <= 4'h0;
    end else begin
      REF_LOOP_EN <= reg_enable[`BIT_REF_LOOP_EN];
      SYN_LOOP_EN <= reg_enable[`BIT_SYN_LOOP_EN];
      SYSREF_TIMER_EN <= reg_enable[`BIT_SYSREF_TIMER_EN];
      RF_RESEED_EN <= reg_enable[`BIT_RF_RESEED_EN];
      VCO_SELECT <= reg_enable[4:3];
      CHANNEL_EN <= next_channel_en;
      REF_ONE_EXT_VCO <= reg_mode[`BIT_REF_ONE_EXT_VCO];
      REF_ZERO_RF_SYNC <= reg_mode[`BIT_REF_ZERO_RF_SYNC];
      REF_PATH_EN <= reg_mode[3:0];
    end
  end

  // Slip, autotune, alarm and alignment events
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      slip_prev <= 1'b0;
      sync_prev <= 1'b0;
      lock_prev <= 1'b0;
      slip_busy <= 1'b0;
      SLIP_REQ <= 1'b0;
      AUTOTUNE_START <= 1'b0;
      ALIGN_EVENT <= 1'b0;
      PULSE_GEN_REQ <= 1'b0;
      ALARM_CLEAR_PULSE <= 1'b0;
      PHASE_SYNC_ALARM <= 1'b0;
    end else begin
      slip_prev <= reg_slip[`BIT_SLIP_REQUEST];
      sync_prev <= SYNC_PIN;
      lock_prev <= SYN_LOOP_LOCKED;
      // Slip request level goes to all dividers, which act on its rise
      SLIP_REQ <= reg_slip[`BIT_SLIP_REQUEST];
      AUTOTUNE_START <= WR_EN & hit(ADDR, `ADDR_SLIP_AUTOTUNE) & WDATA[`BIT_AUTOTUNE];
      ALARM_CLEAR_PULSE <= WR_EN & hit(ADDR, `ADDR_ALARM_CLEAR) & WDATA[`BIT_CLEAR_ALARMS];
      if (slip_rise) begin
        slip_busy <= 1'b1;
      end else if (slip_busy && SLIP_DONE) begin
        slip_busy <= 1'b0;
      end
      // Completion sets the alarm; set wins over a simultaneous clear
      if (slip_busy && SLIP_DONE) begin
        PHASE_SYNC_ALARM <= 1'b1;
      end else if (ALARM_CLEAR_PULSE) begin
        PHASE_SYNC_ALARM <= 1'b0;
      end
      // Alignment from pin or lock; pulse request from pin or general input
      ALIGN_EVENT <= (sync_rise && ((pin_mode == `SYNC_MODE_ALIGN) ||
                      (pin_mode == `SYNC_MODE_AUTO && ALARM_PRESENT))) ||
                     (lock_rise && !reg_lock[`BIT_LOCK_ALIGN_DIS]);
      PULSE_GEN_REQ <= GPI_PULSE_REQ || (sync_rise && ((pin_mode == `SYNC_MODE_PULSE) ||
                       (pin_mode == `SYNC_MODE_AUTO && !ALARM_PRESENT)));
    end
  end

endmodule // global_control_registers
`default_nettype wire

// ==== bench/global_control_registers_props.sv ====
// Concurrent checks on the ports of the global control register bank
`timescale 1ns/10ps
`default_nettype none
module gcr_props (
  // Clock, reset and bus
  input wire logic REF_CLK, ARST_N, WR_EN,
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  // Status in, controls out
  input wire logic SLIP_DONE, SYN_LOOP_LOCKED, SYNC_PIN, GPI_PULSE_REQ, SLIP_REQ, AUTOTUNE_START,
  input wire logic REF_LOOP_EN, SYN_LOOP_EN, ALIGN_EVENT, PULSE_GEN_REQ, ALARM_CLEAR_PULSE, PHASE_SYNC_ALARM
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // Write decodes
  wire wr_slip = WR_EN && ADDR == 12'h002;
  wire wr_clr = WR_EN && ADDR == 12'h006 && WDATA[0];
  AST_AUTOTUNE: assert property (wr_slip && WDATA[2] |=> AUTOTUNE_START) else $error("no autotune");
  AST_CLR_PULSE: assert property (wr_clr |=> ALARM_CLEAR_PULSE) else $error("no clear pulse");
  AST_CLR_ALARM: assert property (ALARM_CLEAR_PULSE && !SLIP_DONE |=> !PHASE_SYNC_ALARM) else $error("alarm kept");
  AST_LOOP_EN: assert property (WR_EN && ADDR == 12'h003 |-> ##2
    REF_LOOP_EN == $past(WDATA[0], 2) && SYN_LOOP_EN == $past(WDATA[1], 2)) else $error("loop enable");
  AST_SLIP_ALARM: assert property (SLIP_REQ && SLIP_DONE && !ALARM_CLEAR_PULSE |=> PHASE_SYNC_ALARM)
    else $error("slip alarm missing");
  AST_ALARM_CAUSE: assert property (!PHASE_SYNC_ALARM && !SLIP_DONE |=> !PHASE_SYNC_ALARM) else $error("stray alarm");
  AST_PULSE_CAUSE: assert property (PULSE_GEN_REQ |-> $past(GPI_PULSE_REQ) || $past(SYNC_PIN) && !$past(SYNC_PIN, 2))
    else $error("stray pulse");
  AST_ALIGN_CAUSE: assert property (ALIGN_EVENT |-> $past(SYNC_PIN) && !$past(SYNC_PIN, 2)
    || $past(SYN_LOOP_LOCKED) && !$past(SYN_LOOP_LOCKED, 2)) else $error("stray align");
  // Main scenarios reached
  C_ALIGN: cover property (ALIGN_EVENT);
  C_PULSE: cover property (PULSE_GEN_REQ);
  C_ALARM: cover property ($rose(PHASE_SYNC_ALARM));
endmodule // gcr_props
bind global_control_registers gcr_props chk (.*);
`default_nettype wire

// ==== bench/global_control_registers_bench.sv ====
// Self-checking bench for the global control register bank
`timescale 1ns/10ps
`default_nettype none
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module global_control_registers_bench;
  logic REF_CLK = 0, ARST_N = 0, WR_EN = 0, RD_EN = 0, SLIP_DONE = 0, ALARM_PRESENT = 0;
  logic SYN_LOOP_LOCKED = 0, SYNC_PIN = 0, GPI_PULSE_REQ = 0, RVALID, SLIP_REQ, AUTOTUNE_START;
  logic REF_LOOP_EN, SYN_LOOP_EN, SYSREF_TIMER_EN, RF_RESEED_EN, REF_ONE_EXT_VCO, REF_ZERO_RF_SYNC;
  logic ALIGN_EVENT, PULSE_GEN_REQ, ALARM_CLEAR_PULSE, PHASE_SYNC_ALARM;
  logic [11:0] ADDR = 0;
  logic [7:0] WDATA = 0, RDATA;
  logic [13:0] CHANNEL_EN;
  logic [3:0] REF_PATH_EN;
  logic [1:0] VCO_SELECT;
  int n_fail = 0, checks_done = 0;
  always #5 REF_CLK = ~REF_CLK;
  global_control_registers dut (.*);
  // Bus helpers, driven on the falling edge
  task cyc(input int n); repeat (n) @(negedge REF_CLK); endtask
  task wr(input [11:0] a, input [7:0] d);
    @(negedge REF_CLK); WR_EN = 1; ADDR = a; WDATA = d;
    @(negedge REF_CLK); WR_EN = 0;
  endtask
  task rd(input [11:0] a, input [7:0] e);
    @(negedge REF_CLK); RD_EN = 1; ADDR = a;
    @(negedge REF_CLK); RD_EN = 0;
    `CK(RVALID, 1'b1)
    `CK(RDATA, e)
  endtask
  // Reset values, readback, unmapped space and level controls
  task t_regs;
    rd(12'h003, 8'h00);
    wr(12'h008, 8'hA5); rd(12'h008, 8'hA5);
    wr(12'h007, 8'h3C); rd(12'h007, 8'h3C);
    wr(12'h00A, 8'hFF); rd(12'h00A, 8'h00);
    wr(12'h003, 8'h27); wr(12'h004, 8'h55); wr(12'h005, 8'h3A); cyc(2);
    `CK({REF_LOOP_EN, SYN_LOOP_EN, SYSREF_TIMER_EN, RF_RESEED_EN}, 4'hF)
    `CK(CHANNEL_EN, 14'h3333)
    `CK({REF_ONE_EXT_VCO, REF_ZERO_RF_SYNC, REF_PATH_EN}, 6'h3A)
    wr(12'h003, 8'h02); wr(12'h004, 8'h2A); wr(12'h005, 8'h05); cyc(2);
    `CK({REF_LOOP_EN, SYN_LOOP_EN, SYSREF_TIMER_EN, RF_RESEED_EN}, 4'h4)
    `CK(CHANNEL_EN, 14'h0CCC)
    `CK({REF_ONE_EXT_VCO, REF_ZERO_RF_SYNC, REF_PATH_EN}, 6'h05)
    wr(12'h003, 8'h18); cyc(2); `CK(VCO_SELECT, 2'b11)
  endtask
  // Slip with autotune, completion alarm and alarm clear
  task t_slip;
    wr(12'h002, 8'h06); `CK(AUTOTUNE_START, 1'b1)
    cyc(2); `CK(SLIP_REQ, 1'b1)
    `CK(PHASE_SYNC_ALARM, 1'b0)
    SLIP_DONE = 1; cyc(1); SLIP_DONE = 0;
    `CK(PHASE_SYNC_ALARM, 1'b1)
    wr(12'h006, 8'h01); `CK(ALARM_CLEAR_PULSE, 1'b1)
    cyc(1); `CK(PHASE_SYNC_ALARM, 1'b0)
    wr(12'h002, 8'h00); cyc(2); `CK(SLIP_REQ, 1'b0)
  endtask
  // Every pin mode without alarm and auto mode with alarm, then lock alignment on and off
  task t_pin;
    logic [1:0] m;
    for (int i = 0; i < 5; i++) begin
      m = i > 3 ? 2'd3 : i[1:0];
      wr(12'h005, {m, 6'h00}); ALARM_PRESENT = i == 4; cyc(2);
      SYNC_PIN = 1; cyc(1);
      `CK({ALIGN_EVENT, PULSE_GEN_REQ}, {i == 1 || i == 4, i == 2 || i == 3})
      SYNC_PIN = 0; cyc(1);
    end
    GPI_PULSE_REQ = 1; cyc(1); GPI_PULSE_REQ = 0;
    `CK(PULSE_GEN_REQ, 1'b1)
    for (int j = 0; j < 2; j++) begin
      wr(12'h009, j[7:0]); cyc(1); SYN_LOOP_LOCKED = 1; cyc(1);
      `CK(ALIGN_EVENT, j == 0)
      SYN_LOOP_LOCKED = 0; cyc(1);
    end
  endtask
  task complete_run;
    $display("Checks %0d, failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge REF_CLK);
    @(negedge REF_CLK); ARST_N = 1;
    t_regs; t_slip; t_pin;
    complete_run;
  end
  // Watchdog well beyond the expected hundred or so cycles
  initial begin
    #20000; n_fail++; complete_run;
  end
endmodule // global_control_registers_bench
`default_nettype wire
